// ### rtl/ipmc_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
`include "ipmc_defines.svh"

// Functional notes
// - global enable zero blocks all interrupts; one accepts individually enabled sources.
// - primary enable register holds adc, uart, timer1, ext1, timer0, ext0 enables.
// - capture-timer enable register holds overflow, compare 2..0, capture 3..0 enables.
// - enable bit zero disables its source, one enables it.
// - primary level register holds adc, uart, timer1, ext1, timer0, ext0 levels.
// - capture-timer level register holds overflow, compare and capture levels.
// - level bit zero means low priority, one means high.
// - idle halts the cpu; interrupt, serial and timer logic keep running.
// - idle entry stops capture timer, resets both pulse outputs high, aborts adc.
// - timers, watchdog, serial port, external interrupts stay active in idle.
// - powerdown request settable only while watchdog enable pin is high.
// - idle starts right after the write that sets the idle request.
// - idle leaves cpu registers and ram untouched.
// - any enabled interrupt clears idle request, waking the cpu.
// - two general flags written with the idle write, readable afterwards.
// - idle also ends on watchdog or hardware reset held two machine cycles.
// - powerdown stops the oscillator; only ram content is guaranteed kept.
// - powerdown exits only by hardware reset, held until oscillator stable.
// - ale and program store enable 1 in idle, 0 in powerdown; port 0 floats when running from external memory.
// - powerdown from external memory restores port 2 latch data to pins.
// - powerdown wins when both requests are written together.
// - high level beats low; low routine preempted only by high; high never.
// - same-level ties served in fixed order ext0, adc, timer0 ... overflow.
module ipmc_ctrl (
	input  wire logic                  clk_i,
	input  wire logic                  resetn_i,
	input  wire logic [7:0]            sfr_addr_i,
	input  wire logic [7:0]            sfr_wdata_i,
	input  wire logic                  sfr_wr_i,
	output logic      [7:0]            sfr_rdata_o,
	output logic                       sfr_hit_o,
	input  wire logic                  ext0_req_i,
	input  wire logic                  timer0_req_i,
	input  wire logic                  ext1_req_i,
	input  wire logic                  timer1_req_i,
	input  wire logic                  uart_req_i,
	input  wire logic                  adc_req_i,
	input  wire logic [3:0]            capture_req_i,
	input  wire logic [2:0]            compare_req_i,
	input  wire logic                  cap_timer_overflow_req_i,
	input  wire logic                  watchdog_enable_pin_n_i,
	input  wire logic                  ext_mem_i,
	input  wire logic                  irq_ack_i,
	input  wire logic                  return_from_interrupt_i,
	output logic                       irq_req_o,
	output logic      [3:0]            irq_src_o,
	output logic                       cpu_halt_o,
	output logic                       osc_stop_o,
	output logic                       periph_idle_reset_o,
	output logic                       pwm_force_high_o,
	output logic                       adc_abort_o,
	output logic                       ale_force_o,
	output logic                       ale_force_val_o,
	output logic                       program_store_enable_force_o,
	output logic                       program_store_enable_val_o,
	output logic                       port0_float_o,
	output logic                       port2_restore_o,
	output logic      [1:0]            active_level_o
);

	logic [7:0]          iep_q, iep_d;
	logic [7:0]          ilp_q, ilp_d;
	logic [7:0]          iect_q, iect_d;
	logic [7:0]          ilct_q, ilct_d;
	logic [7:0]          pwr_q, pwr_d;
	ipmc_pkg::ipmc_mode_t mode_q, mode_d;
	logic [1:0]          inserv_q, inserv_d;
	logic [3:0]          src_q, src_d;
	logic                req_q, req_d;

	// address decode
	wire wr_iep  = sfr_wr_i && (sfr_addr_i == `IPMC_ADDR_IEP);
	wire wr_ilp  = sfr_wr_i && (sfr_addr_i == `IPMC_ADDR_ILP);
	wire wr_iect = sfr_wr_i && (sfr_addr_i == `IPMC_ADDR_IECT);
	wire wr_ilct = sfr_wr_i && (sfr_addr_i == `IPMC_ADDR_ILCT);
	wire wr_pwr  = sfr_wr_i && (sfr_addr_i == `IPMC_ADDR_PWR);

	assign sfr_hit_o = (sfr_addr_i == `IPMC_ADDR_IEP) || (sfr_addr_i == `IPMC_ADDR_ILP) ||
			(sfr_addr_i == `IPMC_ADDR_IECT) || (sfr_addr_i == `IPMC_ADDR_ILCT) ||
			(sfr_addr_i == `IPMC_ADDR_PWR);
	assign sfr_rdata_o = (sfr_addr_i == `IPMC_ADDR_IEP)  ? iep_q  :
			(sfr_addr_i == `IPMC_ADDR_ILP)  ? ilp_q  :
			(sfr_addr_i == `IPMC_ADDR_IECT) ? iect_q :
			(sfr_addr_i == `IPMC_ADDR_ILCT) ? ilct_q :
			(sfr_addr_i == `IPMC_ADDR_PWR)  ? pwr_q  : `IPMC_RST_BYTE;

	// sources arranged in tie-break order, index 0 served first
	wire [`IPMC_NSRC-1:0] raw_vec = {cap_timer_overflow_req_i, capture_req_i[3], uart_req_i,
			compare_req_i[2], capture_req_i[2], timer1_req_i, compare_req_i[1], capture_req_i[1],
			ext1_req_i, compare_req_i[0], capture_req_i[0], timer0_req_i, adc_req_i,
			ext0_req_i};
	wire [`IPMC_NSRC-1:0] en_vec = {iect_q[7], iect_q[3], iep_q[`IPMC_BIT_UART], iect_q[6],
			iect_q[2], iep_q[`IPMC_BIT_TIMER1], iect_q[5], iect_q[1], iep_q[`IPMC_BIT_EXT1],
			iect_q[4], iect_q[0], iep_q[`IPMC_BIT_TIMER0], iep_q[`IPMC_BIT_ADC],
			iep_q[`IPMC_BIT_EXT0]};
	wire [`IPMC_NSRC-1:0] lvl_vec = {ilct_q[7], ilct_q[3], ilp_q[`IPMC_BIT_UART], ilct_q[6],
			ilct_q[2], ilp_q[`IPMC_BIT_TIMER1], ilct_q[5], ilct_q[1], ilp_q[`IPMC_BIT_EXT1],
			ilct_q[4], ilct_q[0], ilp_q[`IPMC_BIT_TIMER0], ilp_q[`IPMC_BIT_ADC],
			ilp_q[`IPMC_BIT_EXT0]};

	ipmc_pkg::ipmc_vec_t pend;
	assign pend = raw_vec & en_vec & {`IPMC_NSRC{iep_q[`IPMC_BIT_GLOBAL]}};
	wire [`IPMC_NSRC-1:0] pend_hi = pend & lvl_vec;
	wire [`IPMC_NSRC-1:0] pend_lo = pend & ~lvl_vec;

	// fixed-order pick: lowest index wins, generated as a chain
	logic [3:0] hi_idx [`IPMC_NSRC:0];
	logic [3:0] lo_idx [`IPMC_NSRC:0];
	assign hi_idx[`IPMC_NSRC] = `IPMC_NONE;
	assign lo_idx[`IPMC_NSRC] = `IPMC_NONE;
	genvar g;
	generate
		// ascending index keeps the genvar non-negative; the chain still resolves from the top down
		for (g = 0; g < `IPMC_NSRC; g = g + 1) begin : g_pick
			assign hi_idx[g] = pend_hi[g] ? 4'(g) : hi_idx[g+1];
			assign lo_idx[g] = pend_lo[g] ? 4'(g) : lo_idx[g+1];
		end
	endgenerate

	wire hi_any = |pend_hi;
	wire lo_any = |pend_lo;
	// high routines are never preempted; low only by high
	wire can_hi = !inserv_q[1];
	wire can_lo = (inserv_q == 2'b00);
	wire take_hi = hi_any && can_hi;
	wire take_lo = !take_hi && lo_any && can_lo;

	// the cpu acknowledges only while running; idle wake needs any enabled request
	wire wake = (mode_q == ipmc_pkg::IPMC_IDLE) && (|pend);

	always_comb begin
		req_d = req_q;
		src_d = src_q;
		if (irq_ack_i && req_q) begin
			req_d = 1'b0;
		end else if (!req_q && mode_q != ipmc_pkg::IPMC_PDOWN) begin
			if (take_hi) begin
				req_d = 1'b1;
				src_d = hi_idx[0];
			end else if (take_lo) begin
				req_d = 1'b1;
				src_d = lo_idx[0];
			end
		end
	end

	// in-service stack: bit1 high level active, bit0 low level active
	always_comb begin
		inserv_d = inserv_q;
		if (irq_ack_i && req_q) begin
			if (lvl_vec[src_q]) begin
				inserv_d[1] = 1'b1;
			end else begin
				inserv_d[0] = 1'b1;
			end
		end else if (return_from_interrupt_i) begin
			if (inserv_q[1]) begin
				inserv_d[1] = 1'b0;
			end else begin
				inserv_d[0] = 1'b0;
			end
		end
	end

	// power-down may be set only with the watchdog disabled (pin high)
	wire pd_ok  = watchdog_enable_pin_n_i;
	wire set_pd = wr_pwr && sfr_wdata_i[`IPMC_BIT_PD] && pd_ok;
	wire set_id = wr_pwr && sfr_wdata_i[`IPMC_BIT_IDL] && !set_pd;

	always_comb begin
		pwr_d = pwr_q;
		if (wr_pwr) begin
			// general flags ride along with the idle write
			pwr_d = sfr_wdata_i & `IPMC_PWR_MASK;
			pwr_d[`IPMC_BIT_PD] = set_pd;
			pwr_d[`IPMC_BIT_IDL] = set_id;
		end
		if (wake) begin
			pwr_d[`IPMC_BIT_IDL] = 1'b0;
		end
	end

	always_comb begin
		mode_d = mode_q;
		case (mode_q)
			ipmc_pkg::IPMC_RUN: begin
				if (set_pd) begin
					mode_d = ipmc_pkg::IPMC_PDOWN;
				end else if (set_id) begin
					mode_d = ipmc_pkg::IPMC_IDLE;
				end
			end
			ipmc_pkg::IPMC_IDLE: begin
				if (wake) begin
					mode_d = ipmc_pkg::IPMC_RUN;
				end
			end
			// only reset leaves power-down
			ipmc_pkg::IPMC_PDOWN: mode_d = ipmc_pkg::IPMC_PDOWN;
			default: mode_d = ipmc_pkg::IPMC_RUN;
		endcase
	end

	assign iep_d  = wr_iep  ? (sfr_wdata_i & `IPMC_IEP_MASK) : iep_q;
	assign ilp_d  = wr_ilp  ? (sfr_wdata_i & `IPMC_ILP_MASK) : ilp_q;
	assign iect_d = wr_iect ? sfr_wdata_i : iect_q;
	assign ilct_d = wr_ilct ? sfr_wdata_i : ilct_q;

	// hardware and watchdog reset both arrive on resetn_i; the two-cycle hold is the source's duty
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			iep_q    <= `IPMC_RST_BYTE;
			ilp_q    <= `IPMC_RST_BYTE;
			iect_q   <= `IPMC_RST_BYTE;
			ilct_q   <= `IPMC_RST_BYTE;
			pwr_q    <= `IPMC_RST_BYTE;
			mode_q   <= ipmc_pkg::IPMC_RUN;
			inserv_q <= 2'b00;
			src_q    <= `IPMC_NONE;
			req_q    <= 1'b0;
		end else begin
			iep_q    <= iep_d;
			ilp_q    <= ilp_d;
			iect_q   <= iect_d;
			ilct_q   <= ilct_d;
			pwr_q    <= pwr_d;
			mode_q   <= mode_d;
			inserv_q <= inserv_d;
			src_q    <= src_d;
			req_q    <= req_d;
		end
	end

	wire in_idle = (mode_q == ipmc_pkg::IPMC_IDLE);
	wire in_pd   = (mode_q == ipmc_pkg::IPMC_PDOWN);

	assign irq_req_o = req_q;
	assign irq_src_o = src_q;
	// cpu state is held by halting its clock, so nothing is lost in idle
	assign cpu_halt_o = in_idle || in_pd;
	assign osc_stop_o = in_pd;
	assign periph_idle_reset_o = in_idle;
	assign pwm_force_high_o = in_idle || in_pd;
	assign adc_abort_o = in_idle;
	assign ale_force_o = in_idle || in_pd;
	assign ale_force_val_o = in_idle;
	assign program_store_enable_force_o = in_idle || in_pd;
	assign program_store_enable_val_o = in_idle;
	assign port0_float_o = (in_idle || in_pd) && ext_mem_i;
	assign port2_restore_o = in_pd && ext_mem_i;
	assign active_level_o = inserv_q;

endmodule : ipmc_ctrl
`default_nettype wire

// ### rtl/ipmc_defines.svh
`ifndef IPMC_DEFINES_SVH
`define IPMC_DEFINES_SVH

// special function register addresses
`define IPMC_ADDR_IEP      8'ha8
`define IPMC_ADDR_ILP      8'hb8
`define IPMC_ADDR_IECT     8'he8
`define IPMC_ADDR_ILCT     8'hf8
`define IPMC_ADDR_PWR      8'h87

// reset values
`define IPMC_RST_BYTE      8'h00

// primary enable / level bit positions
`define IPMC_BIT_GLOBAL    7
`define IPMC_BIT_ADC       6
`define IPMC_BIT_UART      4
`define IPMC_BIT_TIMER1    3
`define IPMC_BIT_EXT1      2
`define IPMC_BIT_TIMER0    1
`define IPMC_BIT_EXT0      0

// writable masks: reserved bits read zero
`define IPMC_IEP_MASK      8'hdf
`define IPMC_ILP_MASK      8'h5f
`define IPMC_PWR_MASK      8'hbf

// power control bit positions
`define IPMC_BIT_GF1       3
`define IPMC_BIT_GF0       2
`define IPMC_BIT_PD        1
`define IPMC_BIT_IDL       0

// source count, index width and the no-source code
`define IPMC_NSRC          14
`define IPMC_SRC_W         4
`define IPMC_NONE          4'hf

`endif

// ### rtl/ipmc_pkg.sv
`include "ipmc_defines.svh"
package ipmc_pkg;
	typedef enum logic [1:0] {
		IPMC_RUN   = 2'b00,
		IPMC_IDLE  = 2'b01,
		IPMC_PDOWN = 2'b10
	} ipmc_mode_t;
	typedef logic [`IPMC_NSRC-1:0] ipmc_vec_t;
endpackage : ipmc_pkg

// ### verif/ipmc_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
// core side: takes a request after LAT cycles, runs one routine of RET cycles; it never nests
module ipmc_cpu_model #(parameter int LAT = 1, parameter int RET = 6) (
	input  wire logic clk_i,
	input  wire logic irq_req_i,
	output var logic  irq_ack_o,
	output var logic  return_o
);
	initial begin
		irq_ack_o = 0;
		return_o = 0;
		forever begin
			@(negedge clk_i);
			if (irq_req_i === 1'b1) begin
				repeat (LAT) @(negedge clk_i);
				irq_ack_o = 1;
				@(negedge clk_i);
				irq_ack_o = 0;
				repeat (RET) @(negedge clk_i);
				return_o = 1;
				@(negedge clk_i);
				return_o = 0;
			end
		end
	end
endmodule : ipmc_cpu_model
`default_nettype wire

// ### verif/ipmc_ctrl_monitor.sv
`timescale 1ns/1ns
`default_nettype none
`include "ipmc_defines.svh"
module ipmc_monitor (
	input wire logic       clk_i,
	input wire logic       resetn_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic       sfr_wr_i,
	input wire logic [7:0] sfr_rdata_o,
	input wire logic       sfr_hit_o,
	input wire logic       watchdog_enable_pin_n_i,
	input wire logic       irq_ack_i,
	input wire logic       irq_req_o,
	input wire logic [3:0] irq_src_o,
	input wire logic       cpu_halt_o,
	input wire logic       osc_stop_o,
	input wire logic       ale_force_val_o,
	input wire logic       program_store_enable_val_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	wire pwr_wr = sfr_wr_i && sfr_addr_i == `IPMC_ADDR_PWR;
	a_enable_readback: assert property (sfr_wr_i && sfr_addr_i == `IPMC_ADDR_IEP ##1 sfr_addr_i == `IPMC_ADDR_IEP
		|-> sfr_rdata_o == ($past(sfr_wdata_i) & `IPMC_IEP_MASK)) else $error("enable readback wrong");
	a_unmapped_zero: assert property (!sfr_hit_o |-> sfr_rdata_o == 8'h00) else $error("unmapped read not zero");
	a_irq_stands: assert property (irq_req_o && !irq_ack_i |=> irq_req_o && $stable(irq_src_o))
		else $error("request dropped before ack");
	a_ack_clears: assert property (irq_req_o && irq_ack_i |=> !irq_req_o) else $error("request kept after ack");
	a_pd_refused: assert property (pwr_wr && !watchdog_enable_pin_n_i && !osc_stop_o |=> !osc_stop_o)
		else $error("power-down entered with pin low");
	a_pd_wins: assert property (pwr_wr && sfr_wdata_i[1:0] == 2'b11 && watchdog_enable_pin_n_i |=> osc_stop_o)
		else $error("power-down lost to idle");
	a_pd_sticky: assert property (osc_stop_o |=> osc_stop_o) else $error("power-down left without reset");
	a_idle_entry: assert property (pwr_wr && sfr_wdata_i[1:0] == 2'b01 && !osc_stop_o
		|=> cpu_halt_o && ale_force_val_o && program_store_enable_val_o) else $error("idle entry wrong");
	a_pdown_pins: assert property (osc_stop_o |-> !ale_force_val_o && !program_store_enable_val_o)
		else $error("power-down pin levels wrong");
	c_idle: cover property (pwr_wr ##1 cpu_halt_o);
	c_pdown: cover property ($rose(osc_stop_o));
	c_ack: cover property (irq_req_o && irq_ack_i);
endmodule : ipmc_monitor
bind ipmc_ctrl ipmc_monitor u_mon (.clk_i(clk_i), .resetn_i(resetn_i), .sfr_addr_i(sfr_addr_i),
	.sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i), .sfr_rdata_o(sfr_rdata_o), .sfr_hit_o(sfr_hit_o),
	.watchdog_enable_pin_n_i(watchdog_enable_pin_n_i), .irq_ack_i(irq_ack_i), .irq_req_o(irq_req_o),
	.irq_src_o(irq_src_o), .cpu_halt_o(cpu_halt_o), .osc_stop_o(osc_stop_o), .ale_force_val_o(ale_force_val_o),
	.program_store_enable_val_o(program_store_enable_val_o));
`default_nettype wire

// ### verif/tb_interrupt_and_power_mode_control.sv
`timescale 1ns/1ns
`default_nettype none
`include "ipmc_defines.svh"
module tb_interrupt_and_power_mode_control;
	logic        clk_i = 0, resetn_i = 0, wr = 0, pin_n = 1, xmem = 0;
	logic [7:0]  addr = 0, wdata = 0, rdata;
	logic [13:0] req = 0;
	logic        hit, irq, ack, ret, halt, osc, prst, pwm, adc, alef, alev, psef, psev, p0f, p2r;
	logic [3:0]  src;
	logic [1:0]  lvl;
	int          bad_count = 0, checked = 0;
	initial forever #5 clk_i = ~clk_i;
	ipmc_ctrl dut (.clk_i(clk_i), .resetn_i(resetn_i), .sfr_addr_i(addr), .sfr_wdata_i(wdata), .sfr_wr_i(wr),
		.sfr_rdata_o(rdata), .sfr_hit_o(hit), .ext0_req_i(req[0]), .timer0_req_i(req[2]), .ext1_req_i(req[5]),
		.timer1_req_i(req[8]), .uart_req_i(req[11]), .adc_req_i(req[1]), .capture_req_i({req[12], req[9], req[6], req[3]}),
		.compare_req_i({req[10], req[7], req[4]}), .cap_timer_overflow_req_i(req[13]), .watchdog_enable_pin_n_i(pin_n),
		.ext_mem_i(xmem), .irq_ack_i(ack), .return_from_interrupt_i(ret), .irq_req_o(irq), .irq_src_o(src),
		.cpu_halt_o(halt), .osc_stop_o(osc), .periph_idle_reset_o(prst), .pwm_force_high_o(pwm), .adc_abort_o(adc),
		.ale_force_o(alef), .ale_force_val_o(alev), .program_store_enable_force_o(psef),
		.program_store_enable_val_o(psev), .port0_float_o(p0f), .port2_restore_o(p2r), .active_level_o(lvl));
	ipmc_cpu_model cpu (.clk_i(clk_i), .irq_req_i(irq), .irq_ack_o(ack), .return_o(ret));
	task automatic conclude;
		$display("checked=%0d bad_count=%0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : conclude
	task automatic cmp(input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask : cmp
	// hold low 20 cycles, then one spare cycle before the first access
	task automatic reset;
		resetn_i = 0;
		repeat (20) @(negedge clk_i);
		resetn_i = 1;
		@(negedge clk_i);
	endtask : reset
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr = 1;
		@(negedge clk_i);
		wr = 0;
	endtask : wreg
	task automatic rreg(input logic [7:0] a, input logic [7:0] e);
		addr = a;
		#1 cmp(e, rdata);
		@(negedge clk_i);
	endtask : rreg
	// waits bounded, checks the source, lets the core take it, then drops that request
	task automatic serve(input int i);
		repeat (40) if (irq !== 1'b1) @(negedge clk_i);
		cmp(1, irq);
		cmp(i[3:0], src);
		repeat (3) @(negedge clk_i);
		req[i] = 0;
	endtask : serve
	task automatic t_regs;
		logic [7:0] a [5] = '{`IPMC_ADDR_IEP, `IPMC_ADDR_ILP, `IPMC_ADDR_IECT, `IPMC_ADDR_ILCT, `IPMC_ADDR_PWR};
		logic [7:0] d [5] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hfc};
		logic [7:0] e [5] = '{8'hdf, 8'h5f, 8'hff, 8'hff, 8'hbc};
		for (int i = 0; i < 5; i++) begin
			rreg(a[i], 8'h00);
			wreg(a[i], d[i]);
			rreg(a[i], e[i]);
		end
		wreg(8'h90, 8'hff);
		rreg(8'h90, 8'h00);
		cmp(0, hit);
	endtask : t_regs
	task automatic t_global;
		wreg(`IPMC_ADDR_IEP, 8'h7f);
		req[0] = 1;
		repeat (4) @(negedge clk_i);
		cmp(0, irq);
		wreg(`IPMC_ADDR_IEP, 8'hfe);
		repeat (4) @(negedge clk_i);
		cmp(0, irq);
		wreg(`IPMC_ADDR_IEP, 8'h81);
		serve(0);
	endtask : t_global
	task automatic t_order;
		wreg(`IPMC_ADDR_IEP, 8'hff);
		wreg(`IPMC_ADDR_IECT, 8'hff);
		req = '1;
		for (int i = 0; i < 14; i++) serve(i);
	endtask : t_order
	task automatic t_level;
		wreg(`IPMC_ADDR_IEP, 8'h81);
		wreg(`IPMC_ADDR_IECT, 8'h80);
		wreg(`IPMC_ADDR_ILCT, 8'h80);
		req[0] = 1;
		req[13] = 1;
		serve(13);
		cmp(2'b10, lvl);
		cmp(0, irq);
		serve(0);
	endtask : t_level
	task automatic t_idle;
		wreg(`IPMC_ADDR_IEP, 8'h82);
		wreg(`IPMC_ADDR_PWR, 8'h0d);
		cmp(8'hfc, {halt, prst, pwm, adc, alev, psev, osc, p0f});
		cmp(8'h03, {6'h00, alef, psef});
		cmp(8'h00, {7'h00, p2r});
		req[2] = 1;
		serve(2);
		cmp(0, halt);
		rreg(`IPMC_ADDR_PWR, 8'h0c);
	endtask : t_idle
	task automatic t_pdown;
		pin_n = 0;
		wreg(`IPMC_ADDR_PWR, 8'h02);
		cmp(0, osc);
		pin_n = 1;
		xmem = 1;
		wreg(`IPMC_ADDR_PWR, 8'h03);
		cmp(8'h13, {3'h0, osc, alev, psev, p0f, p2r});
		cmp(8'h07, {5'h00, alef, psef, pwm});
		reset();
		cmp(0, osc);
	endtask : t_pdown
	initial begin
		#100000;
		bad_count++;
		conclude();
	end
	initial begin
		reset();
		t_regs();
		reset();
		t_global();
		reset();
		t_order();
		reset();
		t_level();
		reset();
		t_idle();
		reset();
		t_pdown();
		conclude();
	end
endmodule : tb_interrupt_and_power_mode_control
`default_nettype wire
